// ### chassis_monitor_limits_status_tb.sv
// chassis_monitor_limits_status_tb: self-checking bench for cml_monitor
// assumes: the package, the monitor, its checker and the backplane model
`timescale 1ns/10ps
`default_nettype none

module chassis_monitor_limits_status_tb;
    logic clk_sys_i = 1'b0;               // 40 MHz
    logic resetn_i  = 1'b0;               // sync, low
    cml_pkg::cml_cmd_t   cmd;              // command strobes
    cml_pkg::cml_query_t q;                // query strobe
    logic [11:0] amb;                      // ambient temperature
    logic [11:0] slot_t [13];              // slot temperatures
    logic [11:0] rl [13];                  // programmed rise limits
    logic [6:0]  volt;                     // supply flags
    logic [1:0]  fail;                     // sysfail, acfail levels
    logic        aov;                      // ambient alarm level
    logic        fire;                     // backplane cycle request
    logic [2:0]  src;                      // backplane source
    logic        berr;                     // bus-error pulse
    logic [7:1]  ack;                      // ack pulses
    logic [15:0] d;                        // last answer
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [4:0]  summary;
    logic [7:0]  lv;                       // chosen limit
    logic [31:0] seed = 32'h0000_0048;     // xorshift state
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    cml_monitor uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_i(cmd), .query_i(q),
        .ambient_temp_i(amb), .slot_temp_i(slot_t), .ambient_over_i(aov),
        .volt_out_i(volt), .fan_out_i(4'h0), .time_out_i(3'h0), .buserr_evt_i(berr),
        .ack_evt_i(ack), .sysfail_asserted_i(fail[0]), .acfail_asserted_i(fail[1]),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .summary_o(summary));
    cml_backplane_model bp (.clk_sys_i(clk_sys_i), .fire_i(fire), .src_i(src),
        .buserr_evt_o(berr), .ack_evt_o(ack));

    // ------------------------------------------------------------
    // helpers; every task but stop_test is entered at a falling edge
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected bus-event condition word for one monitored source
    function automatic logic [15:0] bev(input logic [2:0] s, input int c, input logic [7:0] l);
        if (l == 8'h00 || c <= int'(l)) return 16'h0000;
        return 16'h0001 << ((s == 3'h0) ? 0 : s + 2);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic lim(input logic [2:0] s, input logic [7:0] v);
        cmd.limit_wr = 1'b1; cmd.limit_src = s; cmd.limit_val = v;
        @(negedge clk_sys_i) cmd.limit_wr = 1'b0;
    endtask
    task automatic clr(input logic [2:0] s);
        cmd.clear = 1'b1; cmd.clear_src = s;
        @(negedge clk_sys_i) cmd.clear = 1'b0;
    endtask
    // answer is looked at in its one valid cycle; a missing strobe reads x
    task automatic qry(input logic [3:0] k, input logic [3:0] i, input cml_pkg::cml_attr_t a);
        q.rd = 1'b1; q.kind = k; q.index = i; q.attr = a;
        @(negedge clk_sys_i) d = rd_valid ? rd_data : 16'hxxxx;
        q.rd = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic pulse(input logic [2:0] s, input int c);
        src = s;
        if (c != 0) begin
            fire = 1'b1;
            repeat (c) @(negedge clk_sys_i);
            fire = 1'b0;
        end
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // hang guard, well above the several hundred cycles the tests take
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cmd = '0; q = '0; volt = 7'h00; fire = 1'b0; src = 3'h0; amb = 12'h100;
        fail = 2'b00; aov = 1'b0;
        foreach (slot_t[i]) slot_t[i] = 12'h100;
        repeat (12) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        qry(cml_pkg::CML_RD_LIMIT, 4'h0, cml_pkg::CML_Q_BUS); chk(d, 16'h0000);
        $display("reset state done");
        // every source in turn, with traffic on a neighbour that must be ignored
        for (int s = 0; s < 8; s++) begin
            lv = 8'(rnd() % 4) + 8'h01;
            n = int'(rnd() % 8);
            lim(3'(s), lv);
            pulse(3'(s), n);
            pulse(3'(s + 1), 2);
            qry(cml_pkg::CML_RD_LIMIT, 4'(s), cml_pkg::CML_Q_BUS); chk(d, {8'h00, lv});
            for (int k = 0; k < 8; k++) begin
                qry(cml_pkg::CML_RD_COUNT, 4'(k), cml_pkg::CML_Q_BUS);
                chk(d, (k == s) ? 16'(n) : 16'h0000);
            end
            qry(cml_pkg::CML_RD_COND, 4'h0, cml_pkg::CML_Q_BUS); chk(d & 16'h03f9, bev(3'(s), n, lv));
            clr(3'(s + 1));
            qry(cml_pkg::CML_RD_COUNT, 4'(s), cml_pkg::CML_Q_BUS); chk(d, 16'(n));
            clr(3'(s));
            qry(cml_pkg::CML_RD_COUNT, 4'(s), cml_pkg::CML_Q_BUS); chk(d, 16'h0000);
        end
        $display("source select done");
        lim(3'h2, 8'hff);
        pulse(3'h2, 300);
        qry(cml_pkg::CML_RD_COUNT, 4'h2, cml_pkg::CML_Q_BUS); chk(d, 16'h0100);
        fail = 2'b11;
        qry(cml_pkg::CML_RD_COND, 4'h0, cml_pkg::CML_Q_BUS); chk(d & 16'h03ff, 16'h0016);
        lim(3'h5, 8'h09);
        qry(cml_pkg::CML_RD_COUNT, 4'h5, cml_pkg::CML_Q_BUS); chk(d, 16'h0000);
        lim(3'h1, 8'h00);
        pulse(3'h1, 4);
        qry(cml_pkg::CML_RD_COUNT, 4'h1, cml_pkg::CML_Q_BUS); chk(d, 16'h0000);
        $display("saturation and zero limit done");
        // odd slots sit one above their limit, even ones exactly on it
        amb = 12'h100 + 12'(rnd() % 64);
        for (int i = 0; i < 13; i++) begin
            rl[i] = 12'(rnd() % 200);
            slot_t[i] = amb + rl[i] + 12'(i % 2);
            cmd.rise_wr = 1'b1; cmd.rise_slot = 4'(i); cmd.rise_val = rl[i];
            @(negedge clk_sys_i) cmd.rise_wr = 1'b0;
            @(negedge clk_sys_i);
        end
        foreach (rl[i]) begin
            qry(cml_pkg::CML_RD_RISE, 4'(i), cml_pkg::CML_Q_TEMP); chk(d, {4'h0, rl[i]});
        end
        aov = 1'b1;
        qry(cml_pkg::CML_RD_COND, 4'h0, cml_pkg::CML_Q_TEMP); chk(d, 16'h2aaa);
        $display("slot rise done");
        cmd.enab_wr = 1'b1; cmd.enab_attr = cml_pkg::CML_Q_VOLT; cmd.enab_val = 16'h007f;
        @(negedge clk_sys_i) cmd.enab_wr = 1'b0;
        qry(cml_pkg::CML_RD_EVENT, 4'h0, cml_pkg::CML_Q_VOLT);
        volt = 7'(rnd()) | 7'h01;
        repeat (4) @(negedge clk_sys_i);
        chk({11'h000, summary}, 16'h0001);
        qry(cml_pkg::CML_RD_COND, 4'h0, cml_pkg::CML_Q_VOLT); chk(d, {9'h000, volt});
        qry(cml_pkg::CML_RD_EVENT, 4'h0, cml_pkg::CML_Q_VOLT); chk(d, {9'h000, volt});
        qry(cml_pkg::CML_RD_EVENT, 4'h0, cml_pkg::CML_Q_VOLT); chk(d, 16'h0000);
        chk({11'h000, summary}, 16'h0000);
        cmd.enab_wr = 1'b1; cmd.enab_val = 16'h0000;
        @(negedge clk_sys_i) cmd.enab_wr = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        $display("status registers done");
        stop_test();
    end
endmodule

`default_nettype wire

// ### cml_backplane_model.sv
// cml_backplane_model: backplane side, emits completed bus cycles
// assumes: fire_i and src_i driven by the bench on the falling edge
`timescale 1ns/10ps
`default_nettype none

module cml_backplane_model (
    input  wire logic       clk_sys_i,    // system clock
    input  wire logic       fire_i,       // one completed cycle per clock
    input  wire logic [2:0] src_i,        // 0 bus error, 1..7 ack level
    output logic            buserr_evt_o, // bus-error cycle done
    output logic [7:1]      ack_evt_o     // ack cycle done, per level
);
    // ------------------------------------------------------------
    // cycle emitter
    // ------------------------------------------------------------
    logic [7:0] one_hot;                  // level select, bit 0 unused
    assign one_hot = 8'h01 << src_i;
    // launched on the rising edge by nonblocking update, so the monitor
    // sees each pulse settled at the following edge, one cycle long
    always @(posedge clk_sys_i) begin
        buserr_evt_o <= fire_i && (src_i == 3'h0);
        ack_evt_o    <= fire_i ? one_hot[7:1] : 7'h00;
    end
endmodule

`default_nettype wire

// ### cml_monitor.sv
// cml_monitor: limit checking, bus event counting and status hierarchy
// assumes: inputs synchronous to clk_sys_i; event pulses one cycle per
// completed backplane cycle; one command or query per cycle at most
//
// Behaviour
// R1: compare slot rise above ambient to limit
// R2: separate rise limit for slots 0 to 12
// R3: rise limits readable back unchanged
// R4: only one event source monitored
// R5: writing a limit selects that source
// R6: event-count limit is eight bits, 0..255
// R7: zero limit disables all event monitoring
// R8: count query zero for unmonitored sources
// R9: counter saturates at 256 until cleared
// R10: clear to monitored source zeroes counter
// R11: changing monitored source zeroes counter
// R12: clear to other source is ignored
// R13: condition, event, enable for five attributes
// R14: condition bits follow present state
// R15: voltage bits 0..6, upper bits zero
// R16: voltage condition reads 0 to 127
// R17: temperature bits 0..12 slots, 13 ambient
// R18: bus-event bit map errors, fails, acks
// R19: event bits latch rises, clear on read
// R20: event AND enable ORed into summary
// R21: count selected source only when limit nonzero
// R22: over-limit when count exceeds limit
`timescale 1ns/10ps
`default_nettype none

module cml_monitor (
    input  wire logic                          clk_sys_i,      // 40 MHz
    input  wire logic                          resetn_i,       // synchronous, low
    input  wire cml_pkg::cml_cmd_t             cmd_i,          // command strobes
    input  wire cml_pkg::cml_query_t           query_i,        // query strobe
    input  wire logic [cml_pkg::TEMP_W-1:0]    ambient_temp_i, // measured ambient
    input  wire logic [cml_pkg::TEMP_W-1:0]    slot_temp_i [cml_pkg::SLOT_COUNT],
    input  wire logic                          ambient_over_i, // ambient alarm
    input  wire logic [cml_pkg::VOLT_BITS-1:0] volt_out_i,     // supply out of tol
    input  wire logic [3:0]                    fan_out_i,      // fan out of tol
    input  wire logic [2:0]                    time_out_i,     // elapsed time over
    input  wire logic                          buserr_evt_i,   // bus-error cycle done
    input  wire logic [7:1]                    ack_evt_i,      // ack cycle done
    input  wire logic                          sysfail_asserted_i,
    input  wire logic                          acfail_asserted_i,
    output logic [cml_pkg::COND_W-1:0]         rd_data_o,      // query answer
    output logic                               rd_valid_o,     // answer strobe
    output logic [cml_pkg::ATTR_COUNT-1:0]     summary_o       // per-attribute
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // map attribute to its summary bit index, used for enable and event
    function automatic int attr_index(input cml_pkg::cml_attr_t a);
        case (a)
            cml_pkg::CML_Q_VOLT: attr_index = 0;
            cml_pkg::CML_Q_FAN:  attr_index = 1;
            cml_pkg::CML_Q_TEMP: attr_index = 2;
            cml_pkg::CML_Q_TIME: attr_index = 3;
            default:             attr_index = 4;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [cml_pkg::TEMP_W-1:0]   rise_limit [cml_pkg::SLOT_COUNT]; // per slot
    logic [cml_pkg::LIMIT_W-1:0]  event_limit;      // one limit, one source
    logic [cml_pkg::SOURCE_W-1:0] event_src;        // monitored source
    logic [cml_pkg::COUNT_W-1:0]  event_count;      // 0..256
    logic [cml_pkg::SLOT_COUNT-1:0] slot_over;      // per-slot comparison
    logic [cml_pkg::COND_W-1:0]   cond [cml_pkg::ATTR_COUNT];
    logic [cml_pkg::COND_W-1:0]   cond_q [cml_pkg::ATTR_COUNT]; // previous
    logic [cml_pkg::COND_W-1:0]   evt [cml_pkg::ATTR_COUNT];    // latched
    logic [cml_pkg::COND_W-1:0]   enab [cml_pkg::ATTR_COUNT];
    logic                         src_hit;          // selected source pulsed
    logic                         count_over;       // count above limit
    logic [cml_pkg::COND_W-1:0]   next_rd_data;
    logic [cml_pkg::ATTR_COUNT-1:0] evt_rd;         // event read this cycle

    // ------------------------------------------------------------------
    // slot temperature rise check
    // ------------------------------------------------------------------
    // rise is measured above ambient; a slot cooler than ambient never trips
    genvar s;
    generate
        for (s = 0; s < cml_pkg::SLOT_COUNT; s++) begin : g_slot
            always_ff @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    rise_limit[s] <= cml_pkg::RISE_RESET;
                end else if (cmd_i.rise_wr && cmd_i.rise_slot == 4'(s)) begin
                    rise_limit[s] <= cmd_i.rise_val; // R2
                end
            end
            // compare rise, not absolute temperature
            always_comb begin
                slot_over[s] = (slot_temp_i[s] > ambient_temp_i) &&
                               ((slot_temp_i[s] - ambient_temp_i) > rise_limit[s]); // R1
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // event source, limit and counter
    // ------------------------------------------------------------------
    // a limit write selects its source and restarts the count
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            event_limit <= cml_pkg::LIMIT_RESET;
            event_src   <= cml_pkg::SRC_BUSERR;
        end else if (cmd_i.limit_wr) begin
            event_limit <= cmd_i.limit_val; // R6
            event_src   <= cmd_i.limit_src; // R4 R5
        end
    end

    // only the selected source is seen; others are ignored
    always_comb begin
        if (event_src == cml_pkg::SRC_BUSERR) begin
            src_hit = buserr_evt_i; // R5
        end else begin
            src_hit = ack_evt_i[event_src]; // R4
        end
    end

    // counter: limit write and matching clear both zero it; saturates at 256
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            event_count <= cml_pkg::COUNT_RESET;
        end else if (cmd_i.limit_wr) begin
            event_count <= cml_pkg::COUNT_RESET; // R11
        end else if (cmd_i.clear && cmd_i.clear_src == event_src) begin
            event_count <= cml_pkg::COUNT_RESET; // R10 R12
        end else if (src_hit && event_limit != cml_pkg::LIMIT_RESET &&
                     event_count != cml_pkg::COUNT_CEILING) begin
            event_count <= event_count + 9'h001; // R7 R9 R21
        end
    end

    // compare in nine bits so a count of 256 exceeds a limit of 255
    assign count_over = (event_limit != cml_pkg::LIMIT_RESET) &&
                        (event_count > {1'b0, event_limit}); // R22

    // ------------------------------------------------------------------
    // condition words
    // ------------------------------------------------------------------
    // conditions are present state only, recomputed every cycle
    always_comb begin
        for (int a = 0; a < cml_pkg::ATTR_COUNT; a++) begin
            cond[a] = '0;
        end
        cond[0][cml_pkg::VOLT_BITS-1:0] = volt_out_i;      // R14 R15 R16
        cond[1][3:0] = fan_out_i;                          // R14
        cond[2][cml_pkg::SLOT_COUNT-1:0] = slot_over;      // R17
        cond[2][cml_pkg::TEMP_AMB_BIT] = ambient_over_i;   // R17
        cond[3][2:0] = time_out_i;                         // R14
        cond[4][cml_pkg::BEV_SYSFAIL] = sysfail_asserted_i; // R18
        cond[4][cml_pkg::BEV_ACFAIL]  = acfail_asserted_i;  // R18
        if (event_src == cml_pkg::SRC_BUSERR) begin
            cond[4][cml_pkg::BEV_BUSERR] = count_over;     // R18
        end else begin
            cond[4][cml_pkg::BEV_ACK_BASE + int'(event_src) - 1] = count_over; // R18
        end
    end

    // ------------------------------------------------------------------
    // event and enable registers
    // ------------------------------------------------------------------
    // an event query clears only the attribute it reads
    always_comb begin
        for (int a = 0; a < cml_pkg::ATTR_COUNT; a++) begin
            evt_rd[a] = query_i.rd && query_i.kind == cml_pkg::CML_RD_EVENT &&
                        attr_index(query_i.attr) == a;
        end
    end

    genvar a;
    generate
        for (a = 0; a < cml_pkg::ATTR_COUNT; a++) begin : g_attr
            // previous condition for rise detection
            always_ff @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    cond_q[a] <= '0;
                end else begin
                    cond_q[a] <= cond[a];
                end
            end
            // a rise in the read cycle survives the clear
            always_ff @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    evt[a] <= '0;
                end else if (evt_rd[a]) begin
                    evt[a] <= cond[a] & ~cond_q[a]; // R19
                end else begin
                    evt[a] <= evt[a] | (cond[a] & ~cond_q[a]); // R19
                end
            end
            // enable mask written by the controller
            always_ff @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    enab[a] <= '0;
                end else if (cmd_i.enab_wr && attr_index(cmd_i.enab_attr) == a) begin
                    enab[a] <= cmd_i.enab_val; // R13
                end
            end
            // summary for the next status level
            always_ff @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    summary_o[a] <= 1'b0;
                end else begin
                    summary_o[a] <= |(evt[a] & enab[a]); // R20
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // query answers
    // ------------------------------------------------------------------
    // answers are zero-extended to sixteen bits
    always_comb begin
        next_rd_data = '0;
        case (query_i.kind)
            cml_pkg::CML_RD_RISE: begin
                if (query_i.index < 4'(cml_pkg::SLOT_COUNT)) begin
                    next_rd_data[cml_pkg::TEMP_W-1:0] = rise_limit[query_i.index]; // R3
                end
            end
            cml_pkg::CML_RD_LIMIT: begin
                if (query_i.index[2:0] == event_src) begin
                    next_rd_data[cml_pkg::LIMIT_W-1:0] = event_limit;
                end
            end
            cml_pkg::CML_RD_COUNT: begin
                // unmonitored sources always read zero
                if (query_i.index[2:0] == event_src) begin
                    next_rd_data[cml_pkg::COUNT_W-1:0] = event_count; // R8
                end
            end
            cml_pkg::CML_RD_COND: begin
                next_rd_data = cond[attr_index(query_i.attr)]; // R16
            end
            cml_pkg::CML_RD_EVENT: begin
                next_rd_data = evt[attr_index(query_i.attr)]; // R19
            end
            cml_pkg::CML_RD_ENAB: begin
                next_rd_data = enab[attr_index(query_i.attr)];
            end
            default: begin
                next_rd_data = '0;
            end
        endcase
    end

    // registered answer, one cycle after the query strobe
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rd_data_o  <= '0;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= query_i.rd;
            rd_data_o  <= query_i.rd ? next_rd_data : '0;
        end
    end

endmodule

`default_nettype wire

// ### cml_monitor_props.sv
// cml_monitor_props: port-level checks on the chassis monitor block
// assumes: bound to every cml_monitor, one clock domain, sync reset
`timescale 1ns/10ps
`default_nettype none

module cml_monitor_props (
    input  wire logic                           clk_sys_i,  // system clock
    input  wire logic                           resetn_i,   // sync, low
    input  wire cml_pkg::cml_cmd_t              cmd_i,      // commands
    input  wire cml_pkg::cml_query_t            query_i,    // queries
    input  wire logic [cml_pkg::VOLT_BITS-1:0]  volt_out_i, // supply flags
    input  wire logic [cml_pkg::COND_W-1:0]     rd_data_o,  // answer
    input  wire logic                           rd_valid_o, // answer strobe
    input  wire logic [cml_pkg::ATTR_COUNT-1:0] summary_o   // summaries
);
    // ------------------------------------------------------------
    // shared timing
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // a limit of zero is in force; reset leaves the limit at zero
    logic zero_lim;
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            zero_lim <= 1'b1;
        end else if (cmd_i.limit_wr) begin
            zero_lim <= (cmd_i.limit_val == 8'h00);
        end
    end

    // a count query; answer is in the next cycle
    sequence s_count_rd;
        query_i.rd && query_i.kind == cml_pkg::CML_RD_COUNT;
    endsequence

    // a count query that directly follows a limit write
    sequence s_limit_then_rd(logic zero_only);
        cmd_i.limit_wr && (!zero_only || cmd_i.limit_val == 8'h00) ##1 s_count_rd;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_answer_next_cycle: assert property (query_i.rd |=> rd_valid_o)
        else $error("query not answered in the next cycle");
    a_no_stray_answer: assert property (rd_valid_o |-> $past(query_i.rd))
        else $error("answer strobe without a query");
    a_limit_eight_bit: assert property (query_i.rd && query_i.kind == cml_pkg::CML_RD_LIMIT |=> rd_data_o[15:8] == 8'h00)
        else $error("limit answer wider than eight bits");
    a_count_ceiling: assert property (s_count_rd |=> rd_data_o <= 16'h0100)
        else $error("count answer above ceiling");
    a_zero_limit_off: assert property ((s_count_rd ##0 zero_lim) |=> rd_data_o == 16'h0000)
        else $error("count nonzero after zero limit");
    a_select_zeroes: assert property (s_limit_then_rd(1'b0) |=> rd_data_o == 16'h0000)
        else $error("count not zeroed by source select");
    a_clear_zeroes: assert property (cmd_i.clear ##1 (s_count_rd and query_i.index[2:0] == $past(cmd_i.clear_src)) |=> rd_data_o == 16'h0000)
        else $error("count not zeroed by clear");
    // volt held still for three cycles so condition latency cannot matter
    a_volt_cond_map: assert property (query_i.rd && query_i.kind == cml_pkg::CML_RD_COND && query_i.attr == cml_pkg::CML_Q_VOLT && $stable(volt_out_i) && volt_out_i == $past(volt_out_i, 2) && volt_out_i == $past(volt_out_i, 3) |=> rd_data_o == {9'h000, $past(volt_out_i)})
        else $error("voltage condition word wrong");
    a_enable_gates_sum: assert property (cmd_i.enab_wr && cmd_i.enab_val == 16'h0000 |-> ##2 !summary_o[$past(cmd_i.enab_attr, 2)])
        else $error("summary set with enable cleared");
endmodule

bind cml_monitor cml_monitor_props u_props (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .cmd_i     (cmd_i),
    .query_i   (query_i),
    .volt_out_i(volt_out_i),
    .rd_data_o (rd_data_o),
    .rd_valid_o(rd_valid_o),
    .summary_o (summary_o)
);

`default_nettype wire

// ### cml_pkg.sv
// cml_pkg: constants and carrier types for the chassis monitor limits block
// assumes: one 40 MHz clock, commands arrive as one-cycle strobes from the
// instrument command parser, measurements arrive already digitised
package cml_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int SLOT_COUNT    = 13;              // slots 0 through 12
    localparam int TEMP_W        = 12;              // temperature word width
    localparam int LIMIT_W       = 8;               // event-count limit, 0..255
    localparam int COUNT_W       = 9;               // counter holds 0..256
    localparam int SOURCE_W      = 3;               // 0 bus error, 1..7 ack levels
    localparam int VOLT_BITS     = 7;               // meaningful voltage bits
    localparam int COND_W        = 16;              // every condition word

    // ------------------------------------------------------------------
    // counts and field positions
    // ------------------------------------------------------------------
    localparam logic [COUNT_W-1:0] COUNT_CEILING = 9'h100;  // saturation at 256
    localparam logic [COUNT_W-1:0] COUNT_RESET   = 9'h000;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET   = 8'h00;   // zero: monitoring off
    localparam logic [TEMP_W-1:0]  RISE_RESET    = 12'h000;
    localparam logic [SOURCE_W-1:0] SRC_BUSERR   = 3'h0;
    localparam int TEMP_AMB_BIT  = 13;              // ambient alarm bit
    localparam int BEV_BUSERR    = 0;               // bus-error over limit
    localparam int BEV_SYSFAIL   = 1;               // sysfail asserted
    localparam int BEV_ACFAIL    = 2;               // acfail asserted
    localparam int BEV_ACK_BASE  = 3;               // ack level 1 at bit 3
    localparam int ATTR_COUNT    = 5;               // summary bits

    // query selector for the status read port
    typedef enum logic [2:0] {
        CML_Q_VOLT = 3'h0,
        CML_Q_FAN  = 3'h1,
        CML_Q_TEMP = 3'h2,
        CML_Q_TIME = 3'h3,
        CML_Q_BUS  = 3'h4
    } cml_attr_t;

    // command strobe group from the command parser
    typedef struct packed {
        logic                     rise_wr;      // slot_rise_limit_cmd
        logic [3:0]               rise_slot;
        logic [TEMP_W-1:0]        rise_val;
        logic                     limit_wr;     // buserr/ack_level_limit_cmd
        logic [SOURCE_W-1:0]      limit_src;
        logic [LIMIT_W-1:0]       limit_val;
        logic                     clear;        // count clear command
        logic [SOURCE_W-1:0]      clear_src;
        logic                     enab_wr;      // enable register write
        cml_attr_t                enab_attr;
        logic [COND_W-1:0]        enab_val;
    } cml_cmd_t;

    // query group from the command parser
    typedef struct packed {
        logic                     rd;           // one-cycle read strobe
        logic [3:0]               kind;         // see CML_RD_* below
        logic [3:0]               index;        // slot or source number
        cml_attr_t                attr;
    } cml_query_t;

    localparam logic [3:0] CML_RD_RISE  = 4'h0;  // slot rise limit readback
    localparam logic [3:0] CML_RD_LIMIT = 4'h1;  // event limit readback
    localparam logic [3:0] CML_RD_COUNT = 4'h2;  // event count query
    localparam logic [3:0] CML_RD_COND  = 4'h3;  // condition query
    localparam logic [3:0] CML_RD_EVENT = 4'h4;  // event query, clears
    localparam logic [3:0] CML_RD_ENAB  = 4'h5;  // enable readback

endpackage
